//--- src/mws_pkg.sv
// Operation
// - auto mode: failed madi input swaps to other
// - swap completes within 63 us of the last frame
// - coax input serves madi or word clock
// - mirror mode: same stream on both outputs
// - split mode: two ports, 32 channels each
// - split held separately for input and output
// - midi bytes tunnelled inside madi both ways
// - midi activity lamp reacts to every byte from the madi input in use
// - word clock used only if selected and valid
// - detect single, double, quad word clock speed
// - valid word clock lights lock lamp, status
// - status shows word source once signal valid
// - word clock output runs at sample rate, or at base rate with single speed
// - master: output follows host requested rate
// - slave: output follows recovered input rate
// - reference lost: master at nearest standard rate
// - single speed option folds output to base
// - output slaved to word clock in phase with input
// - setting selects word clock termination
package mws_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NRATES = 9;

  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MIDI_TX = 8'h08;
  localparam logic [7:0] A_MIDI_RX = 8'h0C;
  localparam logic [7:0] A_PERIOD = 8'h10;

  // timing, in the unit given by the name
  localparam int unsigned WC_TIMEOUT_US = 125;
  localparam int unsigned MADI_TIMEOUT_US = 63;
  localparam int unsigned MIDI_ACT_MS = 50;
  localparam int unsigned WC_TIMEOUT_CYC = WC_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MADI_TIMEOUT_CYC =
    MADI_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MIDI_ACT_CYC = MIDI_ACT_MS * (CLK_HZ / 1_000);

  // standard rates, ordered base, double, quad so that code%3 is the family
  localparam int unsigned RATE_HZ [NRATES] = '{32000, 44100, 48000,
    64000, 88200, 96000, 128000, 176400, 192000};

  typedef enum logic [1:0] {
    SRC_INT = 2'b00,
    SRC_WORD = 2'b01,
    SRC_MADI = 2'b10
  } mws_src_e;

  typedef enum logic [1:0] {
    MODE_MASTER = 2'b00,
    MODE_SLAVE = 2'b01,
    MODE_FALLBACK = 2'b10
  } mws_mode_e;

  typedef struct packed {
    logic [3:0] rate;
    logic [1:0] spare;
    logic wc_term;
    logic single;
    logic split_out;
    logic split_in;
    logic mirror;
    logic man_coax;
    logic auto_sel;
    logic coax_wc;
    mws_src_e src;
  } mws_ctrl_s;

  localparam logic [15:0] CTRL_RST = 16'h2008;
  localparam logic [3:0] RATE_DEFAULT = 4'h2;

  typedef struct packed {
    logic frame;
    logic midi_valid;
    logic [7:0] midi_byte;
  } mws_madi_rx_s;

  typedef struct packed {
    logic en;
    logic stream_hi;
    logic limit32;
    logic midi_valid;
    logic [7:0] midi_byte;
  } mws_madi_tx_s;

  typedef struct packed {
    logic use_opt;
    logic use_coax;
    logic limit32;
  } mws_rx_cfg_s;

  typedef logic [15:0] mws_per_t [NRATES];

  function automatic mws_per_t per_table();
    mws_per_t t;
    for (int i = 0; i < NRATES; i++) begin
      t[i] = 16'(CLK_HZ / RATE_HZ[i]);
    end
    return t;
  endfunction

  localparam mws_per_t RATE_PER = per_table();

  // nearest standard rate to a measured period
  function automatic logic [3:0] rate_classify(input logic [15:0] p);
    logic [3:0] best;
    int unsigned bd;
    int unsigned d;
    int unsigned pp;
    int unsigned q;
    best = RATE_DEFAULT;
    bd = 32'hFFFF_FFFF;
    pp = 32'(p);
    for (int i = 0; i < NRATES; i++) begin
      q = 32'(RATE_PER[i]);
      d = (pp > q) ? pp - q : q - pp;
      if (d < bd) begin
        bd = d;
        best = 4'(i);
      end
    end
    return best;
  endfunction
endpackage

//--- src/mws_madi_wc_sync.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module mws_madi_wc_sync #(
  parameter int unsigned WC_TMO_CYC = mws_pkg::WC_TIMEOUT_CYC,
  parameter int unsigned MADI_TMO_CYC = mws_pkg::MADI_TIMEOUT_CYC,
  parameter int unsigned MIDI_ACT_HOLD = mws_pkg::MIDI_ACT_CYC
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input mws_pkg::mws_madi_rx_s opt_rx_in,
  input mws_pkg::mws_madi_rx_s coax_rx_in,
  input wire logic wc_pin_in,
  input wire logic tx_frame_in,
  output mws_pkg::mws_madi_tx_s opt_tx_out,
  output mws_pkg::mws_madi_tx_s coax_tx_out,
  output mws_pkg::mws_rx_cfg_s rx_cfg_out,
  output logic wc_out,
  output logic wc_term_out,
  output logic coax_wc_sel_out,
  output logic wordclock_lock_indicator_out,
  output logic midi_act_out
);
  import mws_pkg::*;

  localparam int NS = 3;
  localparam logic [15:0] PMAX = 16'hFFFF;

  mws_ctrl_s ctrl_q;
  logic s1_q, s2_q, s3_q, wc_lvl_q;
  logic act_coax_q;
  mws_mode_e mode_q;
  logic [3:0] last_ref_q;
  logic [1:0] ecnt_q;
  logic [17:0] div_q;
  logic wc_q;
  logic [7:0] tx_byte_q, rx_byte_q;
  logic tx_pend_q, rx_valid_q;
  logic [31:0] act_cnt_q;
  logic [31:0] rdata_q;
  logic [15:0] cnt_q [NS];
  logic [15:0] per_q [NS];
  logic [NS-1:0] alive_q;

  // filtered pin level moves only when the 2nd and 3rd stage agree
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      wc_lvl_q <= 1'b0;
    end else if (ce_in) begin
      s1_q <= wc_pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        wc_lvl_q <= s3_q;
      end
    end
  end

  // source events; coax frames only count while the jack is madi
  wire wc_rise = (s2_q == s3_q) && s3_q && !wc_lvl_q;
  wire coax_madi = !ctrl_q.coax_wc;
  wire [NS-1:0] ev = {wc_rise & ctrl_q.coax_wc,
                      coax_rx_in.frame & coax_madi,
                      opt_rx_in.frame};

  // per source period meter and silence watchdog
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_src
      localparam logic [15:0] TMO =
        16'((g == 2) ? WC_TMO_CYC : MADI_TMO_CYC);
      always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cnt_q[g] <= 16'h0000;
          per_q[g] <= 16'h0000;
          alive_q[g] <= 1'b0;
        end else if (ce_in) begin
          if (ev[g]) begin
            cnt_q[g] <= 16'h0000;
            per_q[g] <= (cnt_q[g] == PMAX) ? PMAX : cnt_q[g] + 16'h0001;
            alive_q[g] <= (cnt_q[g] < TMO);
          end else begin
            if (cnt_q[g] >= TMO - 16'h0001) begin
              alive_q[g] <= 1'b0;
            end
            if (cnt_q[g] != PMAX) begin
              cnt_q[g] <= cnt_q[g] + 16'h0001;
            end
          end
        end
      end
    end
  endgenerate

  // redundant madi input choice
  wire madi_ok = act_coax_q ? alive_q[1] : alive_q[0];
  wire other_ok = act_coax_q ? alive_q[0] : alive_q[1];
  wire swap_now = ctrl_q.auto_sel && !madi_ok && other_ok;
  wire [15:0] madi_per = act_coax_q ? per_q[1] : per_q[0];

  // rate recovery and clock reference qualification
  wire [3:0] wc_code = rate_classify(per_q[2]);
  wire [3:0] madi_code = rate_classify(madi_per);
  wire [1:0] wc_speed = 2'(wc_code / 4'h3);
  wire wc_valid = alive_q[2];
  wire sel_word = (ctrl_q.src == SRC_WORD);
  wire sel_madi = (ctrl_q.src == SRC_MADI);
  wire ref_ok = (sel_word && wc_valid) || (sel_madi && madi_ok);
  wire [3:0] ref_code = sel_word ? wc_code : madi_code;
  // word is reported active only while the signal is still valid, so the
  // one cycle between loss and fallback never shows a dead source
  wire wc_active = (mode_q == MODE_SLAVE) && sel_word && wc_valid;
  // host codes past the table would index nothing; hold the default rate
  wire host_ok = (ctrl_q.rate < 4'(NRATES));
  wire [3:0] host_code = host_ok ? ctrl_q.rate : RATE_DEFAULT;

  // clock mode: master, slave, or fallback after reference loss
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_q <= MODE_MASTER;
      last_ref_q <= RATE_DEFAULT;
    end else if (ce_in) begin
      case (mode_q)
        MODE_MASTER: begin
          if (ctrl_q.src != SRC_INT && ref_ok) begin
            mode_q <= MODE_SLAVE;
          end
        end
        MODE_SLAVE: begin
          last_ref_q <= ref_code;
          if (ctrl_q.src == SRC_INT) begin
            mode_q <= MODE_MASTER;
          end else if (!ref_ok) begin
            mode_q <= MODE_FALLBACK;
          end
        end
        MODE_FALLBACK: begin
          if (ctrl_q.src == SRC_INT) begin
            mode_q <= MODE_MASTER;
          end else if (ref_ok) begin
            mode_q <= MODE_SLAVE;
          end
        end
        default: mode_q <= MODE_MASTER;
      endcase
    end
  end

  // output rate: host rate, recovered rate, or held nearest rate
  wire [3:0] run_code = (mode_q == MODE_SLAVE) ? ref_code :
                        (mode_q == MODE_FALLBACK) ? last_ref_q :
                        host_code;
  wire [3:0] out_code = ctrl_q.single ? run_code % 4'h3 : run_code;
  wire [1:0] mult_m1 = ctrl_q.single ? ((wc_speed == 2'd2) ? 2'd3 :
                        (wc_speed == 2'd1) ? 2'd1 : 2'd0) : 2'd0;
  wire [17:0] slv_per = 18'(per_q[2]) * (18'(mult_m1) + 18'd1);
  wire [17:0] half = wc_active ? (slv_per >> 1) :
                     18'(RATE_PER[out_code] >> 1);
  wire phase_sync = wc_active && wc_rise && (ecnt_q == 2'd0);

  // word clock generator; while slaved to word clock, rising edges come only from input edges
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wc_q <= 1'b0;
      div_q <= 18'h00000;
      ecnt_q <= 2'd0;
    end else if (ce_in) begin
      if (wc_active && wc_rise) begin
        ecnt_q <= (ecnt_q >= mult_m1) ? 2'd0 : ecnt_q + 2'd1;
      end
      if (phase_sync) begin
        wc_q <= 1'b1;
        div_q <= 18'h00000;
      end else if (div_q + 18'h00001 >= half) begin
        div_q <= 18'h00000;
        if (!wc_active || wc_q) begin
          wc_q <= !wc_q;
        end
      end else begin
        div_q <= div_q + 18'h00001;
      end
    end
  end

  // madi port modes, registered toward the framers
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      act_coax_q <= 1'b0;
      opt_tx_out <= '0;
      coax_tx_out <= '0;
      rx_cfg_out <= '0;
    end else if (ce_in) begin
      if (!ctrl_q.auto_sel) begin
        act_coax_q <= ctrl_q.man_coax;
      end else if (swap_now) begin
        act_coax_q <= !act_coax_q;
      end
      opt_tx_out <= {1'b1, 1'b0, ctrl_q.split_out, tx_pend_q, tx_byte_q};
      coax_tx_out <= {ctrl_q.mirror | ctrl_q.split_out,
                      ctrl_q.split_out, ctrl_q.split_out,
                      tx_pend_q, tx_byte_q};
      rx_cfg_out <= {ctrl_q.split_in | !act_coax_q,
                     coax_madi & (ctrl_q.split_in | act_coax_q),
                     ctrl_q.split_in};
    end
  end

  // midi from the madi side; split input takes either, optical first
  wire opt_mv = opt_rx_in.midi_valid && (ctrl_q.split_in || !act_coax_q);
  wire coax_mv = coax_rx_in.midi_valid && coax_madi &&
                 (ctrl_q.split_in || act_coax_q);
  wire rx_mv = opt_mv || coax_mv;
  wire [7:0] rx_mb = opt_mv ? opt_rx_in.midi_byte : coax_rx_in.midi_byte;

  // apb decode; zero wait states, frozen with the clock enable
  wire acc = psel_in && penable_in && ce_in;
  wire wr = acc && pwrite_in;
  wire rd = acc && !pwrite_in;
  wire hit = (paddr_in == A_CTRL) || (paddr_in == A_STATUS) ||
             (paddr_in == A_MIDI_TX) || (paddr_in == A_MIDI_RX) ||
             (paddr_in == A_PERIOD);
  wire [31:0] status = {12'h000, wc_code, out_code, 3'b000,
                        act_cnt_q != 32'h0, madi_ok, act_coax_q,
                        mode_q, wc_speed, wc_active, wc_valid};
  wire [31:0] rmux =
    (paddr_in == A_CTRL) ? {16'h0000, ctrl_q} :
    (paddr_in == A_STATUS) ? status :
    (paddr_in == A_MIDI_TX) ? {23'h000000, tx_pend_q, tx_byte_q} :
    (paddr_in == A_MIDI_RX) ? {23'h000000, rx_valid_q, rx_byte_q} :
    (paddr_in == A_PERIOD) ? {16'h0000, per_q[2]} : 32'h0000_0000;
  assign pready_out = ce_in;
  assign pslverr_out = psel_in && penable_in && !hit;
  assign prdata_out = rdata_q;

  // read data caught in the setup cycle so it leaves a flip-flop
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
    end else if (ce_in) begin
      if (psel_in && !penable_in) begin
        rdata_q <= rmux;
      end
      if (wr && paddr_in == A_CTRL) begin
        ctrl_q <= pwdata_in[15:0];
      end
    end
  end

  // midi tunnel registers; a new event wins over a same cycle clear
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_byte_q <= 8'h00;
      tx_pend_q <= 1'b0;
      rx_byte_q <= 8'h00;
      rx_valid_q <= 1'b0;
      act_cnt_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (wr && paddr_in == A_MIDI_TX) begin
        tx_byte_q <= pwdata_in[7:0];
        tx_pend_q <= 1'b1;
      end else if (tx_frame_in) begin
        tx_pend_q <= 1'b0;
      end
      if (rx_mv) begin
        rx_byte_q <= rx_mb;
        rx_valid_q <= 1'b1;
      end else if (rd && paddr_in == A_MIDI_RX) begin
        rx_valid_q <= 1'b0;
      end
      if (rx_mv) begin
        act_cnt_q <= MIDI_ACT_HOLD;
      end else if (act_cnt_q != 32'h0) begin
        act_cnt_q <= act_cnt_q - 32'h0000_0001;
      end
    end
  end

  assign wc_out = wc_q;
  assign wc_term_out = ctrl_q.wc_term;
  assign coax_wc_sel_out = ctrl_q.coax_wc;
  assign wordclock_lock_indicator_out = wc_valid;
  assign midi_act_out = (act_cnt_q != 32'h0);

  // helper: cycles since the word clock output last moved
  logic [31:0] stay_q;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stay_q <= 32'h0;
    end else if (ce_in) begin
      stay_q <= (wc_q != $past(wc_q)) ? 32'h0 : stay_q + 32'h1;
    end
  end

  a_auto_swap: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ce_in && swap_now |=> act_coax_q != $past(act_coax_q))
    else $error("auto input swap missed");
  a_coax_shared: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_q.coax_wc |-> !ev[1] && !coax_mv)
    else $error("coax madi used in word clock mode");
  a_mirror_out: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ce_in && ctrl_q.mirror && !ctrl_q.split_out |=>
    coax_tx_out.en && !coax_tx_out.stream_hi)
    else $error("mirror output wrong");
  a_split_limit: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ce_in && ctrl_q.split_out && !ctrl_q.split_in |=> coax_tx_out.limit32
    && opt_tx_out.limit32 && !rx_cfg_out.limit32)
    else $error("split limits wrong");
  a_midi_lamp: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ce_in && rx_mv |=> midi_act_out [*2])
    else $error("midi activity not shown");
  a_word_ref: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wc_active |-> wc_valid && wordclock_lock_indicator_out)
    else $error("word source without valid signal");
  a_fall_back: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ce_in && mode_q == MODE_SLAVE && !ref_ok && ctrl_q.src != SRC_INT
    |=> mode_q == MODE_FALLBACK && last_ref_q == $past(ref_code))
    else $error("no fallback on reference loss");
  a_single_out: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ctrl_q.single |-> out_code < 4'h3)
    else $error("single speed output above base rate");
  a_phase_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ce_in && phase_sync |=> wc_out && div_q == 18'h0)
    else $error("slaved output not phase aligned");
  a_wc_running: assert property (@(posedge clock_in) disable iff (!nrst_in)
    stay_q < 32'(4 * WC_TMO_CYC))
    else $error("word clock output stalled");
  // output rate checks, only without the single speed fold
  a_host_rate: assert property (@(posedge clock_in) disable iff (!nrst_in)
    mode_q == MODE_MASTER && !ctrl_q.single |-> out_code == host_code)
    else $error("master output not at host rate");
  a_slave_rate: assert property (@(posedge clock_in) disable iff (!nrst_in)
    mode_q == MODE_SLAVE && !ctrl_q.single |-> out_code == ref_code)
    else $error("slave output not at recovered rate");
endmodule

//--- verif/mws_far_model.sv
`timescale 1ns/1ps
module mws_far_model
  import mws_pkg::*;
(
  input wire logic clock_in,
  input wire logic wc_run_in,
  input wire logic [15:0] wc_half_in,
  input wire logic opt_run_in,
  input wire logic coax_run_in,
  input wire logic midi_go_in,
  input wire logic [7:0] midi_byte_in,
  output logic wc_pin_out,
  output mws_pkg::mws_madi_rx_s opt_rx_out,
  output mws_pkg::mws_madi_rx_s coax_rx_out
);
  logic [15:0] wc_cnt_q = 16'h0000;
  logic [3:0] frm_cnt_q = 4'h0;
  logic [7:0] idle_b;

  initial begin
    wc_pin_out = 1'b0;
  end

  // far word clock master; the block must slave to it, never both master
  always @(posedge clock_in) begin
    frm_cnt_q <= frm_cnt_q + 4'h1;
    if (!wc_run_in) begin
      wc_cnt_q <= 16'h0000;
    end else if (wc_cnt_q + 16'h0001 >= wc_half_in) begin
      wc_cnt_q <= 16'h0000;
      wc_pin_out <= ~wc_pin_out;
    end else begin
      wc_cnt_q <= wc_cnt_q + 16'h0001;
    end
  end

  // idle byte lines change each cycle so stale data never looks valid
  assign idle_b = {frm_cnt_q, ~frm_cnt_q};
  // optical and coax frames interleaved, midi tunnelled on optical
  assign opt_rx_out = {opt_run_in && frm_cnt_q == 4'h0, midi_go_in,
    midi_go_in ? midi_byte_in : idle_b};
  assign coax_rx_out = {coax_run_in && frm_cnt_q == 4'h8, 1'b0, idle_b};
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mws_pkg::*;
  logic clock_in = 1'b0;
  logic nrst_in, psel, penable, pwrite, tx_frame, wc_pin, wc_out;
  logic wc_run, opt_run, coax_run, midi_go, pready, pslverr;
  logic wc_term, coax_sel, lock, midi_act;
  logic [7:0] paddr, midi_b, b;
  logic [15:0] wc_half;
  logic [31:0] pwdata, prdata, seed, c;
  mws_madi_rx_s opt_rx, coax_rx;
  mws_madi_tx_s opt_tx, coax_tx;
  mws_rx_cfg_s rx_cfg;
  logic [32:0] exq[$];
  logic [31:0] mq[$];
  int err_count = 0;
  int num_checks = 0;

  always #5 clock_in = ~clock_in;

  mws_madi_wc_sync #(.WC_TMO_CYC(400), .MADI_TMO_CYC(200),
    .MIDI_ACT_HOLD(20)) i_mws_madi_wc_sync (.clock_in(clock_in),
    .nrst_in(nrst_in), .ce_in(1'b1), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .opt_rx_in(opt_rx), .coax_rx_in(coax_rx),
    .wc_pin_in(wc_pin), .tx_frame_in(tx_frame), .opt_tx_out(opt_tx),
    .coax_tx_out(coax_tx), .rx_cfg_out(rx_cfg), .wc_out(wc_out),
    .wc_term_out(wc_term), .coax_wc_sel_out(coax_sel),
    .wordclock_lock_indicator_out(lock), .midi_act_out(midi_act));

  mws_far_model i_mws_far_model (.clock_in(clock_in), .wc_run_in(wc_run),
    .wc_half_in(wc_half), .opt_run_in(opt_run), .coax_run_in(coax_run),
    .midi_go_in(midi_go), .midi_byte_in(midi_b), .wc_pin_out(wc_pin),
    .opt_rx_out(opt_rx), .coax_rx_out(coax_rx));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // one apb transfer; reads leave their expected word in the queue
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] ex, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clock_in);
    if (!wr) begin
      exq.push_back(ex);
      mq.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      conclude();
    end
  endtask

  // length of one high phase of the word clock output
  task automatic half(input int exp);
    int h, n;
    h = 0;
    n = 0;
    while (wc_out !== 1'b0 && n < 9000) begin
      tick(1);
      n++;
    end
    while (wc_out !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    while (wc_out === 1'b1 && h < 9000) begin
      tick(1);
      h++;
    end
    if (n >= 9000 || h >= 9000) begin
      err_count++;
      conclude();
    end
    check(33'(h >= exp - 2 && h <= exp + 2), 33'h1);
  endtask

  // read monitor: oldest note is compared when a read completes
  always @(posedge clock_in) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exq.size() > 0) begin
      check({pslverr, prdata & mq[0]}, exq[0]);
      void'(exq.pop_front());
      void'(mq.pop_front());
    end
  end

  initial begin
    seed = 32'h0000_003A;
    {psel, penable, pwrite, tx_frame, midi_go, wc_run} = 6'h00;
    {nrst_in, opt_run, coax_run} = 3'b011;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    midi_b = 8'h00;
    wc_half = 16'h0064;
    tick(16);
    nrst_in <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0, {1'b0, 32'h0000_2008}, 32'h0000_FFFF);
    apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000, 32'hFFFF_FFFF);
    // mirror: both outputs carry one stream
    apb(1'b1, A_CTRL, 32'h0000_2028, 33'h0, 32'h0);
    tick(3);
    check({coax_tx.en, coax_tx}, {1'b1, opt_tx});
    // split out overrides mirror, input split stays off
    apb(1'b1, A_CTRL, 32'h0000_20A8, 33'h0, 32'h0);
    tick(3);
    check({opt_tx.limit32, coax_tx.limit32, coax_tx.stream_hi,
      opt_tx.stream_hi, coax_tx.en, rx_cfg.limit32}, 33'h3A);
    apb(1'b1, A_CTRL, 32'h0000_2048, 33'h0, 32'h0);
    tick(3);
    check({opt_tx.limit32, rx_cfg}, 33'h7);
    // midi byte out, then consumed by the framer
    b = 8'(xs());
    apb(1'b1, A_MIDI_TX, {24'h0, b}, 33'h0, 32'h0);
    tick(3);
    check({opt_tx.midi_valid, opt_tx.midi_byte}, {1'b1, b});
    @(posedge clock_in);
    tx_frame <= 1'b1;
    @(posedge clock_in);
    tx_frame <= 1'b0;
    tick(3);
    check(opt_tx.midi_valid, 33'h0);
    // midi byte in lights the lamp and lands in the rx register
    b = 8'(xs());
    @(posedge clock_in);
    midi_go <= 1'b1;
    midi_b <= b;
    @(posedge clock_in);
    midi_go <= 1'b0;
    tick(3);
    check(midi_act, 33'h1);
    apb(1'b0, A_MIDI_RX, 32'h0, {25'h1, b}, 32'h0000_01FF);
    // optical dies, auto select moves to coax; split off so choice shows
    apb(1'b1, A_CTRL, 32'h0000_2008, 33'h0, 32'h0);
    tick(2);
    check(rx_cfg, 33'h4);
    apb(1'b0, A_STATUS, 32'h0, 33'h80, 32'h0000_00C0);
    opt_run <= 1'b0;
    tick(300);
    apb(1'b0, A_STATUS, 32'h0, 33'hC0, 32'h0000_00C0);
    tick(2);
    check(rx_cfg, 33'h2);
    opt_run <= 1'b1;
    // coax jack to word clock, terminated, word source
    apb(1'b1, A_CTRL, 32'h0000_2205, 33'h0, 32'h0);
    wc_run <= 1'b1;
    tick(800);
    check({coax_sel, wc_term, lock}, 33'h7);
    apb(1'b0, A_STATUS, 32'h0, 33'h8001B, 32'h000F_003F);
    half(100);
    // reference lost: fallback at nearest standard rate
    wc_run <= 1'b0;
    tick(800);
    check(lock, 33'h0);
    apb(1'b0, A_STATUS, 32'h0, 33'h8020, 32'h0000_F030);
    // master at a random host rate, then single speed folding
    c = xs() % 9;
    apb(1'b1, A_CTRL, {16'h0, c[3:0], 12'h000}, 33'h0, 32'h0);
    tick(10);
    apb(1'b0, A_STATUS, 32'h0, {17'h0, c[3:0], 12'h0}, 32'h0000_F030);
    half(int'(RATE_PER[c]) / 2);
    apb(1'b1, A_CTRL, 32'h0000_5100, 33'h0, 32'h0);
    tick(10);
    half(int'(RATE_PER[2]) / 2);
    tick(5);
    conclude();
  end
endmodule
